// ---- rtl/awu_top.sv ----
// Auto wake-up from halt unit: APB registers, halt mode control, RC model.
// Assumes CPU-side inputs are on clk; the RC clock is an enable from clk.
`timescale 1ns/1ps
module awu_top import awu_pkg::*; #(
	parameter int FIX_DIV  = FIX_DIV_DEF,
	parameter int RC_DIV   = RC_DIV_DEF,
	parameter int RC_START = RC_START_DEF
) (
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [APB_AW-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              halt_exec,
	input  wire logic              rtc_interrupt_enable,
	input  wire logic              watchdog_enabled,
	input  wire logic              watchdog_halt_option,
	input  wire logic              exit_irq,
	input  wire logic              stab_long_sel,
	output logic                   timed_halt_mode,
	output logic                   rtc_halt_mode,
	output logic                   main_osc_on,
	output logic                   cpu_clk_en,
	output logic                   cc_mask_load,
	output logic [1:0]             cc_int_mask,
	output logic                   watchdog_reset,
	output logic                   rc_osc_en,
	output logic                   timer_capture_input_one,
	output logic                   wake_irq
);
	localparam int RW = $clog2(RC_DIV + 1);

	// Maps a byte address onto a register select.
	function automatic logic [2:0] awu_decode(input logic [APB_AW-1:0] a);
		case (a)
			ADDR_CSR:   awu_decode = DEC_CSR;
			ADDR_PRESC: awu_decode = DEC_PRESC;
			ADDR_ISTAT: awu_decode = DEC_ISTAT;
			ADDR_IMASK: awu_decode = DEC_IMASK;
			default:    awu_decode = DEC_NONE;
		endcase
	endfunction

	logic             pready_ff;
	logic             nxt_pready;
	logic             pslverr_ff;
	logic             nxt_pslverr;
	logic [7:0]       rdata_ff;
	logic [7:0]       nxt_rdata;
	logic             wake_enable_bit_ff;
	logic             nxt_wake_enable_bit;
	logic             rc_measure_enable_ff;
	logic             nxt_rc_measure_enable;
	logic             wake_flag_ff;
	logic             nxt_wake_flag;
	logic [7:0]       presc_ff;
	logic [7:0]       nxt_presc;
	logic [INT_W-1:0] istat_ff;
	logic [INT_W-1:0] nxt_istat;
	logic [INT_W-1:0] imask_ff;
	logic [INT_W-1:0] nxt_imask;
	logic             irq_ff;
	logic             nxt_irq;
	awu_state_t       state_ff;
	awu_state_t       nxt_state;
	logic [12:0]      stab_ff;
	logic [12:0]      nxt_stab;
	logic             osc_ff;
	logic             nxt_osc;
	logic             cpu_ff;
	logic             nxt_cpu;
	logic             cc_load_ff;
	logic             nxt_cc_load;
	logic [1:0]       cc_mask_ff;
	logic [1:0]       nxt_cc_mask;
	logic             wdg_ff;
	logic             nxt_wdg;
	logic             exit_evt;
	logic             rc_en_ff;
	logic             nxt_rc_en;
	logic [RW-1:0]    rc_cnt_ff;
	logic [RW-1:0]    nxt_rc_cnt;
	logic             rc_tick_ff;
	logic             nxt_rc_tick;
	logic             cap_ff;
	logic             nxt_cap;
	logic             timeout;
	logic [2:0]       sel;
	logic             acc_done;
	logic             wr_done;
	logic             rd_done;
	logic             wdg_trip;
	logic [12:0]      stab_len;

	assign sel      = awu_decode(paddr);
	assign acc_done = psel & penable & pready_ff;
	assign wr_done  = acc_done & pwrite;
	assign rd_done  = acc_done & ~pwrite;
	assign wdg_trip = watchdog_enabled & ~watchdog_halt_option
		& ~rtc_interrupt_enable;
	assign stab_len = stab_long_sel ? STAB_LONG : STAB_SHORT;

	// APB slave: one wait state, read data captured before completion.
	always_comb begin
		nxt_pready  = psel & penable & ~pready_ff;
		nxt_pslverr = nxt_pready & (sel == DEC_NONE);
		nxt_rdata   = rdata_ff;
		if (nxt_pready & ~pwrite) begin
			case (sel)
				DEC_CSR:   nxt_rdata = {5'h00, wake_flag_ff,
					rc_measure_enable_ff, wake_enable_bit_ff}; // see [RULE14]
				DEC_PRESC: nxt_rdata = presc_ff;
				DEC_ISTAT: nxt_rdata = {6'h00, istat_ff};
				DEC_IMASK: nxt_rdata = {6'h00, imask_ff};
				default:   nxt_rdata = 8'h00;
			endcase
		end
	end

	// Software registers; only bits actually read are cleared, set wins.
	always_comb begin
		nxt_wake_enable_bit   = wake_enable_bit_ff;
		nxt_rc_measure_enable = rc_measure_enable_ff;
		nxt_presc             = presc_ff;
		nxt_imask             = imask_ff;
		nxt_wake_flag         = wake_flag_ff;
		nxt_istat             = istat_ff;
		if (wr_done && sel == DEC_CSR) begin
			nxt_wake_enable_bit   = pwdata[CSR_EN_BIT]; // see [RULE11]
			nxt_rc_measure_enable = pwdata[CSR_MEAS_BIT];
		end
		if (wr_done && sel == DEC_PRESC && pwdata[7:0] != PRESC_FORBID) begin
			nxt_presc = pwdata[7:0]; // see [RULE13]
		end
		if (wr_done && sel == DEC_IMASK) begin
			nxt_imask = pwdata[INT_W-1:0];
		end
		if (rd_done && sel == DEC_CSR && rdata_ff[CSR_FLAG_BIT]) begin
			nxt_wake_flag           = 1'b0; // see [RULE5]
			nxt_istat[INT_WAKE_BIT] = 1'b0;
		end
		if (rd_done && sel == DEC_ISTAT) begin
			nxt_istat = nxt_istat & ~rdata_ff[INT_W-1:0];
		end
		if (timeout) begin
			nxt_wake_flag           = 1'b1; // see [RULE3]
			nxt_istat[INT_WAKE_BIT] = 1'b1;
		end
		if (exit_evt) begin
			nxt_istat[INT_EXIT_BIT] = 1'b1;
		end
		nxt_irq = |(nxt_istat & nxt_imask);
	end

	// Registers the bus answer and the software registers.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pready_ff            <= 1'b0;
			pslverr_ff           <= 1'b0;
			rdata_ff             <= 8'h00;
			wake_enable_bit_ff   <= CSR_RST[CSR_EN_BIT];
			rc_measure_enable_ff <= CSR_RST[CSR_MEAS_BIT];
			wake_flag_ff         <= CSR_RST[CSR_FLAG_BIT];
			presc_ff             <= PRESC_RST;
			imask_ff             <= IMASK_RST;
			istat_ff             <= '0;
			irq_ff               <= 1'b0;
		end else begin
			pready_ff            <= nxt_pready;
			pslverr_ff           <= nxt_pslverr;
			rdata_ff             <= nxt_rdata;
			wake_enable_bit_ff   <= nxt_wake_enable_bit;
			rc_measure_enable_ff <= nxt_rc_measure_enable;
			wake_flag_ff         <= nxt_wake_flag;
			presc_ff             <= nxt_presc;
			imask_ff             <= nxt_imask;
			istat_ff             <= nxt_istat;
			irq_ff               <= nxt_irq;
		end
	end

	// Halt mode control: entry choice, exit sources and stabilisation.
	always_comb begin
		nxt_state   = state_ff;
		nxt_stab    = stab_ff;
		nxt_cc_load = 1'b0;
		nxt_cc_mask = cc_mask_ff;
		nxt_wdg     = 1'b0;
		exit_evt    = 1'b0;
		case (state_ff)
			AWU_RUN: begin
				if (halt_exec) begin
					if (wdg_trip) begin
						nxt_wdg = 1'b1; // see [RULE10]
					end else begin
						nxt_cc_load = 1'b1;
						nxt_cc_mask = CC_HALT_MASK; // see [RULE8]
						if (rtc_interrupt_enable) begin
							nxt_state = AWU_RTC; // see [RULE15]
						end else if (wake_enable_bit_ff) begin
							nxt_state = AWU_TIMED; // see [RULE1]
						end else begin
							nxt_state = AWU_PLAIN;
						end
					end
				end
			end
			AWU_TIMED, AWU_RTC, AWU_PLAIN: begin
				if (timeout || exit_irq) begin
					nxt_state = AWU_STAB; // see [RULE7]
					nxt_stab  = stab_len;
					exit_evt  = ~timeout;
				end
			end
			AWU_STAB: begin
				if (stab_ff == 13'h0001) begin
					nxt_state = AWU_RUN; // see [RULE4]
				end
				nxt_stab = stab_ff - 13'h0001;
			end
			default: begin
				nxt_state = AWU_RUN;
			end
		endcase
		nxt_osc = ~(nxt_state == AWU_TIMED || nxt_state == AWU_PLAIN);
		nxt_cpu = nxt_state == AWU_RUN; // see [RULE9]
	end

	// Registers the mode state and its outputs.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_ff   <= AWU_RUN;
			stab_ff    <= 13'h0000;
			osc_ff     <= 1'b1;
			cpu_ff     <= 1'b1;
			cc_load_ff <= 1'b0;
			cc_mask_ff <= CC_RST;
			wdg_ff     <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			stab_ff    <= nxt_stab;
			osc_ff     <= nxt_osc;
			cpu_ff     <= nxt_cpu;
			cc_load_ff <= nxt_cc_load;
			cc_mask_ff <= nxt_cc_mask;
			wdg_ff     <= nxt_wdg;
		end
	end

	// RC oscillator model: runs in timed halt or while measuring in run.
	always_comb begin
		nxt_rc_en   = (state_ff == AWU_TIMED) // see [RULE2]
			|| (rc_measure_enable_ff && state_ff == AWU_RUN); // see [RULE6]
		nxt_rc_cnt  = rc_cnt_ff;
		nxt_rc_tick = 1'b0;
		nxt_cap     = cap_ff;
		if (!rc_en_ff) begin
			nxt_rc_cnt = '0;
		end else if (rc_cnt_ff == RW'(RC_DIV - 1)) begin
			nxt_rc_cnt  = '0;
			nxt_rc_tick = 1'b1;
		end else begin
			nxt_rc_cnt = rc_cnt_ff + RW'(1);
		end
		if (rc_tick_ff && rc_measure_enable_ff && state_ff == AWU_RUN) begin
			nxt_cap = ~cap_ff; // see [RULE6]
		end
	end

	// Registers the RC model.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rc_en_ff   <= 1'b0;
			rc_cnt_ff  <= '0;
			rc_tick_ff <= 1'b0;
			cap_ff     <= 1'b0;
		end else begin
			rc_en_ff   <= nxt_rc_en;
			rc_cnt_ff  <= nxt_rc_cnt;
			rc_tick_ff <= nxt_rc_tick;
			cap_ff     <= nxt_cap;
		end
	end

	// Start-up, fixed divider and prescaler chain.
	awu_divchain #(
		.FIX_DIV  (FIX_DIV),
		.RC_START (RC_START)
	) u_chain (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.run      (state_ff == AWU_TIMED),
		.rc_tick  (rc_tick_ff),
		.prescale (presc_ff),
		.timeout  (timeout)
	);

	// Output ports from flip-flops; timed_halt_mode and rtc_halt_mode are decoded from state_ff.
	assign prdata                  = {24'h000000, rdata_ff};
	assign pready                  = pready_ff;
	assign pslverr                 = pslverr_ff;
	assign timed_halt_mode         = state_ff == AWU_TIMED;
	assign rtc_halt_mode           = state_ff == AWU_RTC;
	assign main_osc_on             = osc_ff;
	assign cpu_clk_en              = cpu_ff;
	assign cc_mask_load            = cc_load_ff;
	assign cc_int_mask             = cc_mask_ff;
	assign watchdog_reset          = wdg_ff;
	assign rc_osc_en               = rc_en_ff;
	assign timer_capture_input_one = cap_ff;
	assign wake_irq                = irq_ff;

	// Helper counters that only the checks below read.
	logic [12:0] h_cnt_ff;
	logic [12:0] h_len_ff;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			h_cnt_ff <= 13'h0000;
			h_len_ff <= 13'h0000;
		end else begin
			h_cnt_ff <= (state_ff == AWU_STAB) ? h_cnt_ff + 13'h0001 : 13'h0000;
			h_len_ff <= (state_ff != AWU_STAB) ? stab_len : h_len_ff;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence halt_req_s;
		state_ff == AWU_RUN && halt_exec && !wdg_trip;
	endsequence

	sequence csr_read_s;
		rd_done && sel == DEC_CSR && rdata_ff[CSR_FLAG_BIT] && !timeout;
	endsequence

	timed_entry_a: assert property ( // see [RULE1]
		halt_req_s and (wake_enable_bit_ff && !rtc_interrupt_enable)
		|=> timed_halt_mode && !main_osc_on
	) else $error("Timed halt not entered.");

	rtc_entry_a: assert property ( // see [RULE15]
		halt_req_s and (rtc_interrupt_enable)
		|=> rtc_halt_mode && !timed_halt_mode && main_osc_on
	) else $error("RTC halt not entered.");

	cc_force_a: assert property ( // see [RULE8]
		halt_req_s |=> cc_mask_load && cc_int_mask == 2'h2 ##1 !cc_mask_load
	) else $error("Interrupt mask not forced on halt.");

	halt_quiet_a: assert property ( // see [RULE9]
		timed_halt_mode |-> !main_osc_on && !cpu_clk_en
	) else $error("Clocks running in timed halt.");

	flag_set_a: assert property ( // see [RULE3]
		timeout |=> wake_flag_ff && state_ff == AWU_STAB && main_osc_on
	) else $error("Wake flag or exit missing after timeout.");

	read_clear_a: assert property ( // see [RULE5]
		csr_read_s |=> !wake_flag_ff && !istat_ff[INT_WAKE_BIT]
	) else $error("Control/status read did not clear flag.");

	wdg_reset_a: assert property ( // see [RULE10]
		state_ff == AWU_RUN && halt_exec && wdg_trip
		|=> watchdog_reset && cpu_clk_en ##1 !watchdog_reset
	) else $error("Watchdog reset not raised on halt.");

	exit_other_a: assert property ( // see [RULE7]
		(rtc_halt_mode || state_ff == AWU_PLAIN || timed_halt_mode)
		&& exit_irq |=> state_ff == AWU_STAB && main_osc_on
	) else $error("Halt not left on exit interrupt.");

	stab_bound_a: assert property ( // see [RULE4]
		state_ff == AWU_STAB |-> h_cnt_ff < h_len_ff
	) else $error("Stabilisation runs past its length.");

	stab_len_a: assert property ( // see [RULE4]
		$rose(cpu_clk_en) |-> h_cnt_ff == h_len_ff
	) else $error("Stabilisation length wrong.");

	measure_a: assert property ( // see [RULE6]
		rc_measure_enable_ff && state_ff == AWU_RUN |=> ##[0:1] rc_osc_en
	) else $error("RC oscillator off while measuring.");

	enable_wr_a: assert property ( // see [RULE11]
		wr_done && sel == DEC_CSR
		|=> wake_enable_bit_ff == $past(pwdata[CSR_EN_BIT])
	) else $error("Wake enable bit not written.");

	presc_zero_a: assert property ( // see [RULE13]
		wr_done && sel == DEC_PRESC && pwdata[7:0] == 8'h00 |=> $stable(presc_ff)
	) else $error("Forbidden prescaler value stored.");

	reserved_a: assert property ( // see [RULE14]
		pready && !pwrite && sel == DEC_CSR |-> prdata[7:3] == 5'h00
	) else $error("Reserved control bits read nonzero.");
endmodule

// ---- rtl/awu_pkg.sv ----
// Constants, register map and types of the auto wake-up from halt unit.
// Assumes one 250 MHz clock; the wake RC oscillator is modelled by enables.
// Function
// [RULE1] Halt, wake enabled, RTC off: timed halt
// [RULE2] Timed halt runs RC, divider, then prescaler
// [RULE3] Delay over: set flag, raise wake interrupt
// [RULE4] Oscillator restarts; 256/4096 cycles, then service
// [RULE5] Reading control/status clears flag and interrupt
// [RULE6] Measure bit routes RC clock to capture
// [RULE7] Other wake interrupts or reset also exit
// [RULE8] Halt entry forces interrupt mask to 10b
// [RULE9] Timed halt stops main oscillator and processing
// [RULE10] Watchdog option picks reset or halt
// [RULE11] Wake enable bit is software read/write
// [RULE12] Prescaler value is the dividing factor
// [RULE13] Prescaler value 00h is forbidden
// [RULE14] Flag read-only, bits 7:3 read zero
// [RULE15] RTC on, wake off: RTC halt mode
// [RULE16] Halt time: factor times divider plus start-up
package awu_pkg;
	localparam int          APB_AW       = 10;
	// Register indices; the byte address is four times the index.
	localparam logic [7:0]  IDX_CSR      = 8'h2B;
	localparam logic [7:0]  IDX_PRESC    = 8'h2C;
	localparam logic [7:0]  IDX_ISTAT    = 8'h2D;
	localparam logic [7:0]  IDX_IMASK    = 8'h2E;
	localparam logic [9:0]  ADDR_CSR     = {IDX_CSR, 2'h0};
	localparam logic [9:0]  ADDR_PRESC   = {IDX_PRESC, 2'h0};
	localparam logic [9:0]  ADDR_ISTAT   = {IDX_ISTAT, 2'h0};
	localparam logic [9:0]  ADDR_IMASK   = {IDX_IMASK, 2'h0};
	// Decoded register selects.
	localparam logic [2:0]  DEC_NONE     = 3'h0;
	localparam logic [2:0]  DEC_CSR      = 3'h1;
	localparam logic [2:0]  DEC_PRESC    = 3'h2;
	localparam logic [2:0]  DEC_ISTAT    = 3'h3;
	localparam logic [2:0]  DEC_IMASK    = 3'h4;
	// Control/status fields and reset values.
	localparam int          CSR_EN_BIT   = 0;
	localparam int          CSR_MEAS_BIT = 1;
	localparam int          CSR_FLAG_BIT = 2;
	localparam logic [7:0]  CSR_RST      = 8'h00;
	localparam logic [7:0]  PRESC_RST    = 8'hFF;
	localparam logic [7:0]  PRESC_FORBID = 8'h00;
	// Interrupt status and mask layout.
	localparam int          INT_W        = 2;
	localparam int          INT_WAKE_BIT = 0;
	localparam int          INT_EXIT_BIT = 1;
	localparam logic [1:0]  IMASK_RST    = 2'h0;
	// Interrupt mask value forced on halt entry.
	localparam logic [1:0]  CC_HALT_MASK = 2'h2;
	localparam logic [1:0]  CC_RST       = 2'h0;
	// Oscillator stabilisation counts in CPU cycles.
	localparam logic [12:0] STAB_SHORT   = 13'h0100;
	localparam logic [12:0] STAB_LONG    = 13'h1000;
	// Defaults of the RC model and the fixed divider.
	localparam int          FIX_DIV_DEF  = 16;
	localparam int          RC_DIV_DEF   = 8;
	localparam int          RC_START_DEF = 4;

	typedef enum logic [2:0] {
		AWU_RUN,
		AWU_TIMED,
		AWU_RTC,
		AWU_PLAIN,
		AWU_STAB
	} awu_state_t;
endpackage

// ---- rtl/awu_divchain.sv ----
// Start-up counter, fixed divider and programmable prescaler on RC ticks.
// Assumes rc_tick is a one-cycle enable and prescale is never 00h.
`timescale 1ns/1ps
module awu_divchain import awu_pkg::*; #(
	parameter int FIX_DIV  = FIX_DIV_DEF,
	parameter int RC_START = RC_START_DEF
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       run,
	input  wire logic       rc_tick,
	input  wire logic [7:0] prescale,
	output logic            timeout
);
	localparam int FW = $clog2(FIX_DIV + 1);
	localparam int SW = $clog2(RC_START + 1);

	logic [SW-1:0] start_ff;
	logic [SW-1:0] nxt_start;
	logic [FW-1:0] fix_ff;
	logic [FW-1:0] nxt_fix;
	logic [7:0]    pre_ff;
	logic [7:0]    nxt_pre;
	logic          tout_ff;
	logic          nxt_tout;

	// Counts start-up ticks, then divides by the fixed ratio and prescaler.
	always_comb begin
		nxt_start = start_ff;
		nxt_fix   = fix_ff;
		nxt_pre   = pre_ff;
		nxt_tout  = 1'b0;
		if (!run) begin
			nxt_start = '0;
			nxt_fix   = '0;
			nxt_pre   = 8'h00;
		end else if (rc_tick) begin
			if (start_ff != SW'(RC_START)) begin
				nxt_start = start_ff + SW'(1); // see [RULE16]
			end else if (fix_ff == FW'(FIX_DIV - 1)) begin
				nxt_fix = '0; // see [RULE2]
				if (pre_ff == prescale - 8'h01) begin
					nxt_pre  = 8'h00; // see [RULE12]
					nxt_tout = 1'b1;
				end else begin
					nxt_pre = pre_ff + 8'h01;
				end
			end else begin
				nxt_fix = fix_ff + FW'(1);
			end
		end
	end

	// Registers the counters and the timeout pulse.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			start_ff <= '0;
			fix_ff   <= '0;
			pre_ff   <= 8'h00;
			tout_ff  <= 1'b0;
		end else begin
			start_ff <= nxt_start;
			fix_ff   <= nxt_fix;
			pre_ff   <= nxt_pre;
			tout_ff  <= nxt_tout;
		end
	end

	assign timeout = tout_ff;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	timeout_run_a: assert property ( // see [RULE2]
		timeout |-> $past(run) && $past(rc_tick)
	) else $error("Timeout without a running chain.");
endmodule

// ---- tb/awu_cpu_model.sv ----
// CPU-side partner: executes halt, holds wake interrupts, counts captures.
// Assumes the bench raises halt_req and exit_req just after a rising edge.
`timescale 1ns/1ps
module awu_cpu_model (
	input  wire logic clk,
	input  wire logic halt_req,
	input  wire logic exit_req,
	input  wire logic cpu_clk_en,
	input  wire logic timer_capture_input_one,
	output logic      halt_exec,
	output logic      exit_irq,
	output int        cap_edges
);
	logic cap_q;

	initial begin
		halt_exec = 1'b0;
		exit_irq = 1'b0;
		cap_edges = 0;
		cap_q = 1'b0;
	end

	// Halt only executes while the core is clocked.
	always @(posedge clk) begin
		halt_exec <= halt_req && cpu_clk_en;
	end

	// The request latch stays set until the core runs again.
	always @(posedge clk) begin
		if (exit_req) begin
			exit_irq <= 1'b1;
		end else if (cpu_clk_en) begin
			exit_irq <= 1'b0;
		end
	end

	// The capture timer counts every change of its input.
	always @(posedge clk) begin
		cap_q <= timer_capture_input_one;
		if (cap_q !== timer_capture_input_one) begin
			cap_edges <= cap_edges + 1;
		end
	end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench of the auto wake-up unit over APB.
// Assumes shortened divider counts; both stabilisation lengths are run.
`timescale 1ns/1ps
module tb_top;
	import awu_pkg::*;
	localparam int FD = 2;
	localparam int RD = 2;
	localparam int RS = 1;
	logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [9:0] paddr;
	logic [31:0] pwdata, prdata;
	logic halt_exec, rtc_en, wd_en, wd_opt, exit_irq, stab_long_sel;
	logic timed_halt_mode, rtc_halt_mode, main_osc_on, cpu_clk_en;
	logic cc_mask_load, watchdog_reset, rc_osc_en, cap_in, wake_irq;
	logic [1:0] cc_int_mask;
	logic halt_req, exit_req;
	int cap_edges, bad_count, n_tests, cyc;

	awu_top #(.FIX_DIV(FD), .RC_DIV(RD), .RC_START(RS)) awu_top_inst (
		.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .halt_exec(halt_exec),
		.rtc_interrupt_enable(rtc_en), .watchdog_enabled(wd_en),
		.watchdog_halt_option(wd_opt), .exit_irq(exit_irq),
		.stab_long_sel(stab_long_sel), .timed_halt_mode(timed_halt_mode),
		.rtc_halt_mode(rtc_halt_mode), .main_osc_on(main_osc_on),
		.cpu_clk_en(cpu_clk_en), .cc_mask_load(cc_mask_load),
		.cc_int_mask(cc_int_mask), .watchdog_reset(watchdog_reset),
		.rc_osc_en(rc_osc_en), .timer_capture_input_one(cap_in),
		.wake_irq(wake_irq));

	awu_cpu_model awu_cpu_model_inst (
		.clk(clk), .halt_req(halt_req), .exit_req(exit_req),
		.cpu_clk_en(cpu_clk_en), .timer_capture_input_one(cap_in),
		.halt_exec(halt_exec), .exit_irq(exit_irq), .cap_edges(cap_edges));

	// Prints the verdict and ends the run.
	task automatic results();
		if (bad_count == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Compares one value and counts the outcome.
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, g, x);
		end
	endtask

	// Checks that a cycle count lies in a window.
	task automatic rng(input int g, input int lo, input int hi);
		n_tests++;
		if (g < lo || g > hi) begin
			bad_count++;
			$display("[ERR] %0t count %0d outside %0d..%0d", $time, g, lo, hi);
		end
	endtask

	// One APB transfer; waits for pready at a rising edge.
	task automatic apb(input logic w, input logic [9:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			chk(32'h0, 32'h1);
		end
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, {24'h0, d}, r, e);
	endtask

	task automatic rd(input logic [9:0] a, input logic [7:0] x,
		input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, {24'h0, x});
		chk({31'h0, e}, {31'h0, xe});
	endtask

	function automatic logic sig(input int s);
		case (s)
			0: return timed_halt_mode;
			1: return cpu_clk_en;
			2: return rtc_halt_mode;
			default: return watchdog_reset;
		endcase
	endfunction

	// Counts edges until a watched output reaches a level.
	task automatic wait_lvl(input int s, input logic v, output int k);
		k = 0;
		while (sig(s) !== v && k < 5000) begin
			@(posedge clk);
			k++;
		end
	endtask

	task automatic pulse(input logic h);
		@(posedge clk);
		if (h) halt_req <= 1'b1;
		else exit_req <= 1'b1;
		@(posedge clk);
		halt_req <= 1'b0;
		exit_req <= 1'b0;
	endtask

	// Reset values, reserved bits, forbidden prescaler, unmapped address.
	task automatic t_regs();
		rd(ADDR_CSR, CSR_RST, 1'b0);
		rd(ADDR_PRESC, PRESC_RST, 1'b0);
		wr(ADDR_CSR, 8'hFF);
		rd(ADDR_CSR, 8'h03, 1'b0);
		wr(ADDR_CSR, 8'h00);
		rd(ADDR_CSR, 8'h00, 1'b0);
		wr(ADDR_PRESC, PRESC_FORBID);
		rd(ADDR_PRESC, 8'hFF, 1'b0);
		rd(10'h3FC, 8'h00, 1'b1);
	endtask

	// Measurement routes RC ticks to the capture input in run mode.
	task automatic t_meas();
		int c;
		wr(ADDR_CSR, 8'h02);
		repeat (3) @(posedge clk);
		chk(rc_osc_en, 1'b1);
		c = cap_edges;
		repeat (20) @(posedge clk);
		rng(cap_edges - c, 20 / RD - 1, 20 / RD + 1);
		wr(ADDR_CSR, 8'h00);
		repeat (3) @(posedge clk);
		c = cap_edges;
		repeat (10) @(posedge clk);
		rng(cap_edges - c, 0, 0);
	endtask

	// Timed halt with prescaler p, wake interrupt masked by m.
	task automatic t_timed(input logic [7:0] p, input logic m);
		int k;
		int e;
		e = (RS + FD * p) * RD;
		wr(ADDR_IMASK, {7'h0, m});
		wr(ADDR_PRESC, p);
		wr(ADDR_CSR, 8'h01);
		pulse(1'b1);
		wait_lvl(0, 1'b1, k);
		chk(cc_mask_load, 1'b1);
		chk(cc_int_mask, CC_HALT_MASK);
		chk({main_osc_on, cpu_clk_en}, 2'b00);
		@(posedge clk);
		chk(rc_osc_en, 1'b1);
		wait_lvl(0, 1'b0, k);
		rng(k, e - RD, e + RD + 4);
		wait_lvl(1, 1'b1, k);
		rng(k, 255, 259);
		chk(wake_irq, m);
		rd(ADDR_CSR, 8'h05, 1'b0);
		rd(ADDR_CSR, 8'h01, 1'b0);
		repeat (2) @(posedge clk);
		chk(wake_irq, 1'b0);
	endtask

	// Another wake interrupt ends timed halt; the long delay is selected.
	task automatic t_exit();
		int k;
		stab_long_sel <= 1'b1;
		wr(ADDR_IMASK, 8'h00);
		wr(ADDR_PRESC, 8'hFF);
		pulse(1'b1);
		wait_lvl(0, 1'b1, k);
		repeat (5) @(posedge clk);
		pulse(1'b0);
		wait_lvl(1, 1'b1, k);
		rng(k, 4090, 4105);
		stab_long_sel <= 1'b0;
		rd(ADDR_ISTAT, 8'h02, 1'b0);
		rd(ADDR_CSR, 8'h01, 1'b0);
	endtask

	// RTC enable selects RTC halt; wake off gives plain halt.
	task automatic t_rtc();
		int k;
		rtc_en <= 1'b1;
		pulse(1'b1);
		wait_lvl(2, 1'b1, k);
		chk(timed_halt_mode, 1'b0);
		pulse(1'b0);
		wait_lvl(1, 1'b1, k);
		rng(k, 250, 265);
		rtc_en <= 1'b0;
		wr(ADDR_CSR, 8'h00);
		pulse(1'b1);
		repeat (3) @(posedge clk);
		chk({timed_halt_mode, rtc_halt_mode, cpu_clk_en}, 3'h0);
		pulse(1'b0);
		wait_lvl(1, 1'b1, k);
	endtask

	// Watchdog option decides between reset and timed halt.
	task automatic t_wdg();
		int k;
		wr(ADDR_CSR, 8'h01);
		wd_en <= 1'b1;
		wd_opt <= 1'b0;
		pulse(1'b1);
		wait_lvl(3, 1'b1, k);
		rng(k, 0, 4);
		chk(timed_halt_mode, 1'b0);
		wd_opt <= 1'b1;
		repeat (3) @(posedge clk);
		pulse(1'b1);
		wait_lvl(0, 1'b1, k);
		rng(k, 0, 4);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk({timed_halt_mode, cpu_clk_en}, 2'b01);
		rd(ADDR_CSR, 8'h00, 1'b0);
		wd_en <= 1'b0;
	endtask

	// Clock of 4 ns period.
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Cuts a hang short.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			results();
		end
	end

	// Reset, then the scenarios in turn.
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{rtc_en, wd_en, wd_opt, stab_long_sel} = '0;
		{halt_req, exit_req} = '0;
		bad_count = 0;
		n_tests = 0;
		cyc = 0;
		sys_rst = 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs();
		t_meas();
		t_timed(8'h01, 1'b0);
		t_timed(8'h05, 1'b1);
		t_exit();
		t_rtc();
		t_wdg();
		results();
	end
endmodule
